// ### verilog/phy_irq_map.svh
`ifndef PHY_IRQ_MAP_SVH
`define PHY_IRQ_MAP_SVH

// Management register indices
`define IDX_SRC_FLAGS 5'h1D
`define IDX_EN_MASK 5'h1E
`define IDX_LINK_STAT 5'h1F

// Flag and mask field, bits 7 down to 1
`define FLAG_MSB 7
`define FLAG_LSB 1
`define FLAG_ENERGY 7
`define FLAG_AN_DONE 6
`define FLAG_RFAULT 5
`define FLAG_LINK 4
`define FLAG_ACK 3
`define FLAG_PDF 2
`define FLAG_PAGE 1
`define FLAG_RST 7'h00
`define MASK_RST 7'h00
`define COND_PREV_RST 7'h7F

// Special status register layout
`define DONE_BIT 12
`define RSVD_MSB 11
`define RSVD_LSB 5
`define RSVD_RST 7'h02
`define SPD_MSB 4
`define SPD_LSB 2
`define SPD_RST 3'h0

`define WORD_ZERO 16'h0000

// Energy window: time in ms, clock in kHz, count derived from both
`define ENERGY_WINDOW_MS 256
`define CLK_FREQ_KHZ 100000
`define ENERGY_TICKS (`ENERGY_WINDOW_MS * `CLK_FREQ_KHZ)
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001

`endif

// ### verilog/phy_irq_pkg.sv
package phy_irq_pkg;

  typedef logic [15:0] reg_word_t;
  typedef logic [7:1] flag_vec_t;

  // One management access, handed over by the serial management unit
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] idx;
    logic [15:0] wdata;
  } mgmt_req_s;

  // Conditions reported by the negotiation and link units
  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_up;
    logic partner_ack;
    logic par_det_fault;
    logic page_received;
  } event_src_s;

endpackage

// ### verilog/energy_watch.sv
`timescale 1ns/10ps
`include "phy_irq_map.svh"

module energy_watch
#(
  parameter int unsigned WINDOW_TICKS = `ENERGY_TICKS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic energy_seen,
  output logic line_energy_present
);

  logic [31:0] idle_cnt_ff;
  logic [31:0] nxt_idle_cnt;
  logic present_ff;
  logic nxt_present;
  logic window_end;

  localparam logic [31:0] LAST_TICK = 32'(WINDOW_TICKS - 1);

  assign window_end = (idle_cnt_ff == LAST_TICK);
  // Counter parks at the window end so a long silence cannot wrap
  assign nxt_idle_cnt = energy_seen ? `CNT_ZERO :
                        window_end ? idle_cnt_ff :
                        idle_cnt_ff + `CNT_ONE;
  assign nxt_present = energy_seen ? 1'b1 :
                       window_end ? 1'b0 : present_ff;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      idle_cnt_ff <= `CNT_ZERO;
      present_ff <= 1'b1;
    end
    else
    begin
      idle_cnt_ff <= nxt_idle_cnt;
      present_ff <= nxt_present;
    end
  end

  assign line_energy_present = present_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_energy_drop_time: assert property (
    $fell(present_ff) |-> $past(idle_cnt_ff) == LAST_TICK
  ) else $error("energy status dropped before window end");

endmodule

// ### verilog/phy_interrupt_and_status_regs.sv
`timescale 1ns/10ps
`include "phy_irq_map.svh"

// Function
// - Flag register at index 29, 16 bits, bits 15:8 reserved read-only.
// - Bit 7 latches on energy-detect status event, resets to 0.
// - Bit 6 latches high when auto-negotiation completes.
// - Bit 5 latches high when a remote fault is detected.
// - Bit 4 latches high when link status goes down.
// - Bit 3 latches high on link partner acknowledge.
// - Bit 2 latches high on parallel detection fault.
// - Bit 1 latches high when a negotiation page is received.
// - Mask register at index 30; bits 15:8 and 0 reserved read-only.
// - Mask bits 7:1 read/write, reset zero; 1 enables, 0 masks.
// - Each mask bit governs the flag at the same position.
// - Status register at index 31; bits 15:13 and 1:0 reserved.
// - Bit 12 reads 1 only when auto-negotiation is done; it follows an_done directly and reset does not touch it.
// - Bits 11:5 reset to 0000010b; software writes that, ignores reads.
// - Bits 4:2 report resolved speed and duplex encoding.
// - Energy status drops after 256 ms without energy; reset sets it.
module phy_interrupt_and_status_regs
  import phy_irq_pkg::*;
#(
  parameter int unsigned ENERGY_TICKS = `ENERGY_TICKS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire mgmt_req_s mgmt_req,
  output reg_word_t rd_data,
  output logic rd_valid,
  input wire logic energy_seen,
  input wire event_src_s events,
  input wire logic an_done,
  input wire logic [2:0] resolved_speed_duplex,
  output logic line_energy_present,
  output logic irq
);

  flag_vec_t flags_ff;
  flag_vec_t nxt_flags;
  flag_vec_t mask_ff;
  flag_vec_t nxt_mask;
  flag_vec_t prev_cond_ff;
  flag_vec_t cond;
  flag_vec_t set_vec;
  logic [`RSVD_MSB-`RSVD_LSB:0] rsvd_ff;
  logic [`RSVD_MSB-`RSVD_LSB:0] nxt_rsvd;
  reg_word_t rd_data_ff;
  reg_word_t nxt_rd_data;
  logic rd_valid_ff;
  logic irq_ff;
  logic nxt_irq;
  logic hit_flags;
  logic hit_mask;
  logic hit_stat;
  logic rd_flags;
  logic wr_mask;
  logic wr_stat;
  logic rd_mapped;
  reg_word_t flags_word;
  reg_word_t mask_word;
  reg_word_t stat_word;
  logic energy_level;

  energy_watch #(
    .WINDOW_TICKS(ENERGY_TICKS)
  ) u_energy (
    .clk_sys(clk_sys),
    .srst(srst),
    .energy_seen(energy_seen),
    .line_energy_present(energy_level)
  );

  // Address decode of the three management registers
  assign hit_flags = (mgmt_req.idx == `IDX_SRC_FLAGS);
  assign hit_mask = (mgmt_req.idx == `IDX_EN_MASK);
  assign hit_stat = (mgmt_req.idx == `IDX_LINK_STAT);
  assign rd_flags = mgmt_req.rd & hit_flags;
  assign wr_mask = mgmt_req.wr & hit_mask;
  assign wr_stat = mgmt_req.wr & hit_stat;
  assign rd_mapped = mgmt_req.rd & (hit_flags | hit_mask | hit_stat);

  // Source conditions; link lost is the negated link status
  assign cond[`FLAG_ENERGY] = energy_level;
  assign cond[`FLAG_AN_DONE] = events.an_complete;
  assign cond[`FLAG_RFAULT] = events.remote_fault;
  assign cond[`FLAG_LINK] = ~events.link_up;
  assign cond[`FLAG_ACK] = events.partner_ack;
  assign cond[`FLAG_PDF] = events.par_det_fault;
  assign cond[`FLAG_PAGE] = events.page_received;

  // Only a rising condition is an event, so a steady state after reset
  // does not raise a flag on its own
  assign set_vec = cond & ~prev_cond_ff;

  genvar gi;
  generate
    for (gi = `FLAG_LSB; gi <= `FLAG_MSB; gi = gi + 1)
    begin : g_flag
      // Set beats the clear of a read in the same cycle
      assign nxt_flags[gi] = set_vec[gi] |
        (flags_ff[gi] & ~(rd_flags & ~cond[gi]));
    end
  endgenerate

  assign nxt_mask = wr_mask ? mgmt_req.wdata[`FLAG_MSB:`FLAG_LSB]
                            : mask_ff;
  assign nxt_rsvd = wr_stat ? mgmt_req.wdata[`RSVD_MSB:`RSVD_LSB]
                            : rsvd_ff;
  // Interrupt follows the flags and mask of the same edge
  assign nxt_irq = |(nxt_flags & nxt_mask);

  // Read images; reserved bits fall out as zero from the shifts
  assign flags_word = reg_word_t'(flags_ff) << `FLAG_LSB;
  assign mask_word = reg_word_t'(mask_ff) << `FLAG_LSB;
  assign stat_word = (reg_word_t'(an_done) << `DONE_BIT) |
                     (reg_word_t'(rsvd_ff) << `RSVD_LSB) |
                     (reg_word_t'(resolved_speed_duplex)
                      << `SPD_LSB);

  assign nxt_rd_data = ~mgmt_req.rd ? rd_data_ff :
                       hit_flags ? flags_word :
                       hit_mask ? mask_word :
                       hit_stat ? stat_word : `WORD_ZERO;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      flags_ff <= `FLAG_RST;
      mask_ff <= `MASK_RST;
      prev_cond_ff <= `COND_PREV_RST;
      rsvd_ff <= `RSVD_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      prev_cond_ff <= cond;
      rsvd_ff <= nxt_rsvd;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rd_data_ff <= `WORD_ZERO;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= rd_mapped;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign irq = irq_ff;
  assign line_energy_present = energy_level;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_irq_from_flags: assert property (
    irq == |(flags_ff & mask_ff)
  ) else $error("interrupt does not match enabled flags");

  a_flag_holds_high: assert property (
    !rd_flags |=> (flags_ff & $past(flags_ff)) == $past(flags_ff)
  ) else $error("flag dropped without a read");

  a_read_clears_flags: assert property (
    rd_flags |=> (flags_ff & ~$past(cond) & ~$past(set_vec)) == `FLAG_RST
  ) else $error("flag survived a read with no source");

  a_event_sets_flag: assert property (
    set_vec != `FLAG_RST |=>
      (flags_ff & $past(set_vec)) == $past(set_vec)
  ) else $error("event did not latch its flag");

  a_link_lost_flag: assert property (
    !$past(srst) && $fell(events.link_up) |=> flags_ff[`FLAG_LINK]
  ) else $error("link loss not latched");

  a_energy_flag_set: assert property (
    !$past(srst) && $rose(energy_level) |=> flags_ff[`FLAG_ENERGY]
  ) else $error("energy event not latched");

  a_page_flag_set: assert property (
    !$past(srst) && $rose(events.page_received) |=>
      flags_ff[`FLAG_PAGE]
  ) else $error("page received not latched");

  a_mask_write_back: assert property (
    wr_mask |=> mask_ff == $past(mgmt_req.wdata[`FLAG_MSB:`FLAG_LSB])
  ) else $error("mask write not stored");

  a_flags_read_data: assert property (
    rd_flags |=> rd_valid && rd_data == $past(flags_word)
      && rd_data[15:8] == 8'h00 && !rd_data[0]
  ) else $error("flag read data wrong");

  a_status_read_data: assert property (
    mgmt_req.rd && hit_stat |=>
      rd_data[`SPD_MSB:`SPD_LSB] == $past(resolved_speed_duplex)
      && rd_data[`DONE_BIT] == $past(an_done)
      && rd_data[15:13] == 3'h0 && rd_data[1:0] == 2'h0
  ) else $error("status read data wrong");

  a_mask_gates_irq: assert property (
    mask_ff == `MASK_RST |-> !irq
  ) else $error("interrupt raised with all sources masked");

  // Each source must show in its own flag at the next edge
  a_an_done_flag: assert property (
    !$past(srst) && $rose(events.an_complete) |=>
      flags_ff[`FLAG_AN_DONE]
  ) else $error("negotiation complete not latched");

  a_remote_fault_flag: assert property (
    !$past(srst) && $rose(events.remote_fault) |=>
      flags_ff[`FLAG_RFAULT]
  ) else $error("remote fault not latched");

  a_partner_ack_flag: assert property (
    !$past(srst) && $rose(events.partner_ack) |=>
      flags_ff[`FLAG_ACK]
  ) else $error("partner acknowledge not latched");

  a_par_det_flag: assert property (
    !$past(srst) && $rose(events.par_det_fault) |=>
      flags_ff[`FLAG_PDF]
  ) else $error("parallel detection fault not latched");

  // A flag may only rise from an event, never from a bus write
  a_flag_write_ignored: assert property (
    mgmt_req.wr && hit_flags |=>
      (flags_ff & ~$past(flags_ff) & ~$past(set_vec)) == `FLAG_RST
  ) else $error("write reached the flag register");

  a_no_spurious_flag: assert property (
    !$past(srst) |->
      (flags_ff & ~$past(flags_ff) & ~$past(set_vec)) == `FLAG_RST
  ) else $error("flag rose without an event");

  a_read_keeps_live: assert property (
    rd_flags |=> (flags_ff & $past(flags_ff) & $past(cond))
      == ($past(flags_ff) & $past(cond))
  ) else $error("read cleared a flag whose source is present");

  a_mask_read_data: assert property (
    mgmt_req.rd && hit_mask |=> rd_valid
      && rd_data[`FLAG_MSB:`FLAG_LSB] == $past(mask_ff)
      && rd_data[15:8] == 8'h00 && !rd_data[0]
  ) else $error("mask read data wrong");

  a_mask_holds: assert property (
    !wr_mask |=> mask_ff == $past(mask_ff)
  ) else $error("mask changed without a write");

  a_rsvd_write_back: assert property (
    wr_stat |=> rsvd_ff == $past(mgmt_req.wdata[`RSVD_MSB:`RSVD_LSB])
  ) else $error("status field write not stored");

  a_status_rsvd_read: assert property (
    mgmt_req.rd && hit_stat |=>
      rd_data[`RSVD_MSB:`RSVD_LSB] == $past(rsvd_ff)
  ) else $error("status field read back wrong");

  a_done_bit_read: assert property (
    mgmt_req.rd && hit_stat |=> rd_valid
      && rd_data[`DONE_BIT] == $past(an_done)
  ) else $error("negotiation done bit wrong");

  a_valid_needs_read: assert property (
    !mgmt_req.rd |=> !rd_valid
  ) else $error("read valid without a read");

  a_masked_flag_quiet: assert property (
    (flags_ff & ~mask_ff) != `FLAG_RST
      && (flags_ff & mask_ff) == `FLAG_RST |-> !irq
  ) else $error("masked flag raised the interrupt");

  a_irq_rises: assert property (
    (nxt_flags & nxt_mask) != `FLAG_RST |=> irq
  ) else $error("enabled flag did not raise the interrupt");

  // Values seen at the first edge after reset is released
  a_flags_reset_zero: assert property (
    $past(srst) |-> flags_ff == `FLAG_RST
  ) else $error("flags not cleared by reset");

  a_mask_reset_zero: assert property (
    $past(srst) |-> mask_ff == `MASK_RST
  ) else $error("mask not cleared by reset");

  a_rsvd_reset_value: assert property (
    $past(srst) |-> rsvd_ff == `RSVD_RST
  ) else $error("status field reset value wrong");

  a_irq_reset_low: assert property (
    $past(srst) |-> !irq
  ) else $error("interrupt high after reset");

endmodule

// ### sim/smi_master.sv
`timescale 1ns/10ps
module smi_master
  import phy_irq_pkg::*;
(
  input wire logic clk_sys,
  output mgmt_req_s mgmt_req,
  input wire reg_word_t rd_data,
  input wire logic rd_valid
);
  initial mgmt_req = '0;
  task automatic xfer(input logic wr, input logic [4:0] idx,
    input reg_word_t wd, output reg_word_t rd, output logic ok);
    @(posedge clk_sys);
    #1;
    mgmt_req = {~wr, wr, idx, wd};
    @(posedge clk_sys);
    #1;
    // Idle lines show the inverse so a stale value cannot pass
    mgmt_req = {2'b00, ~idx, ~wd};
    rd = rd_data;
    ok = rd_valid;
  endtask
endmodule

// ### sim/test_phy_interrupt_and_status_regs.sv
`timescale 1ns/10ps
module test_phy_interrupt_and_status_regs
  import phy_irq_pkg::*;
;
  logic clk_sys = 0, srst = 1, energy_seen = 1, an_done = 0;
  logic [2:0] spd = 3'h1;
  event_src_s events = 6'h08;
  mgmt_req_s mgmt_req;
  reg_word_t rd_data;
  logic rd_valid, line_energy_present, irq;
  int fail_count = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  phy_interrupt_and_status_regs #(.ENERGY_TICKS(20))
    phy_interrupt_and_status_regs_i (.clk_sys(clk_sys), .srst(srst),
    .mgmt_req(mgmt_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .energy_seen(energy_seen), .events(events), .an_done(an_done),
    .resolved_speed_duplex(spd), .irq(irq),
    .line_energy_present(line_energy_present));
  smi_master smi_master_i (.clk_sys(clk_sys), .mgmt_req(mgmt_req),
    .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic chk(input reg_word_t got, input reg_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] i, input reg_word_t e);
    reg_word_t d;
    logic v;
    smi_master_i.xfer(1'b0, i, 16'h0000, d, v);
    chk(d, e);
    chk({15'h0000, v}, 16'h0001);
  endtask
  task automatic wr(input logic [4:0] i, input reg_word_t w);
    reg_word_t d;
    logic v;
    smi_master_i.xfer(1'b1, i, w, d, v);
  endtask
  // One-cycle event on source k, then back to idle levels
  task automatic pulse(input int k);
    @(posedge clk_sys);
    #1;
    events = 6'h08 ^ (6'h01 << k);
    @(posedge clk_sys);
    #1;
    events = 6'h08;
  endtask
  task automatic t_reset();
    rd(5'h1D, 16'h0000);
    rd(5'h1E, 16'h0000);
    rd(5'h1F, 16'h0044);
    chk({15'h0000, line_energy_present}, 16'h0001);
    wr(5'h1E, 16'hFFFF);
    rd(5'h1E, 16'h00FE);
    wr(5'h1D, 16'hFFFF);
    rd(5'h1D, 16'h0000);
    $display("reset and access test done");
  endtask
  task automatic t_events();
    for (int k = 0; k < 6; k++)
    begin
      pulse(k);
      chk({15'h0000, irq}, 16'h0001);
      rd(5'h1D, 16'h0002 << k);
      chk({15'h0000, irq}, 16'h0000);
      rd(5'h1D, 16'h0000);
    end
    wr(5'h1E, 16'h00FC);
    pulse(0);
    chk({15'h0000, irq}, 16'h0000);
    wr(5'h1E, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    rd(5'h1D, 16'h0002);
    $display("event flag test done");
  endtask
  task automatic t_energy();
    energy_seen = 0;
    repeat (25) @(posedge clk_sys);
    #1;
    chk({15'h0000, line_energy_present}, 16'h0000);
    energy_seen = 1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({15'h0000, line_energy_present}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rd(5'h1D, 16'h0080);
    $display("energy test done");
  endtask
  task automatic t_status();
    logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
    an_done = 1;
    wr(5'h1F, 16'h0040);
    foreach (codes[j])
    begin
      spd = codes[j];
      rd(5'h1F, 16'h1040 | (16'(codes[j]) << 2));
    end
    $display("status test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 0;
    t_reset();
    t_events();
    t_energy();
    t_status();
    conclude();
  end
  // The whole sequence needs well under 300 cycles
  initial
  begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule
